// ===== hw/wdc_if.sv
`timescale 1ns/1ps
`default_nettype none

interface wdc_if;
  logic [2:0] prescale_sel;
  logic       tap_tick;
  modport pre (input prescale_sel, output tap_tick);
  modport ctl (output prescale_sel, input tap_tick);
endinterface : wdc_if

`default_nettype wire

// ===== hw/wdc_pkg.sv
package wdc_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W  = 8;
  localparam int unsigned PRE_W  = 6;
  localparam int unsigned IRQ_W  = 3;

  // ---------------------------------------------------------------
  // register indexes, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [15:0] IDX_COUNTER = 16'h7023;
  localparam logic [15:0] IDX_KEY     = 16'h7025;
  localparam logic [15:0] IDX_CONTROL = 16'h7029;
  localparam logic [15:0] IDX_SYSCTL  = 16'h7030;
  localparam logic [15:0] IDX_IRQ_STS = 16'h7031;
  localparam logic [15:0] IDX_IRQ_MSK = 16'h7032;

  // ---------------------------------------------------------------
  // control register fields and key codes
  // ---------------------------------------------------------------
  localparam int unsigned FLAG_BIT = 7;
  localparam int unsigned DIS_BIT  = 6;
  localparam int unsigned CHK_HI   = 5;
  localparam int unsigned CHK_LO   = 3;
  localparam int unsigned PS_HI    = 2;
  localparam int unsigned PS_LO    = 0;
  localparam logic [2:0]  CHK_PATTERN = 3'h5;
  localparam logic [7:0]  KEY_ARM     = 8'h55;
  localparam logic [7:0]  KEY_FIRE    = 8'hAA;

  // ---------------------------------------------------------------
  // reset values and counter top
  // ---------------------------------------------------------------
  localparam logic [2:0]       PS_RST   = 3'h0;
  localparam logic             DIS_RST  = 1'b0;
  localparam logic             FLAG_RST = 1'b0;
  localparam logic [CNT_W-1:0] CNT_RST  = 8'h00;
  localparam logic [CNT_W-1:0] CNT_TOP  = 8'hFF;

  // ---------------------------------------------------------------
  // interrupt bits, bus codes, strap timing
  // ---------------------------------------------------------------
  localparam int unsigned IRQ_OVF    = 0;
  localparam int unsigned IRQ_KICK   = 1;
  localparam int unsigned IRQ_DOGRST = 2;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0]  HSIZE_WORD    = 3'h2;
  localparam logic [1:0]  STRAP_WAIT    = 2'h3;

  typedef enum logic [2:0] {
    WDC_RUN  = 3'h1,
    WDC_OVF  = 3'h2,
    WDC_FIRE = 3'h4
  } wdc_run_t;

  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_CNT  = 3'h1,
    SEL_KEY  = 3'h2,
    SEL_CR   = 3'h3,
    SEL_SYS  = 3'h4,
    SEL_STS  = 3'h5,
    SEL_MSK  = 3'h6
  } wdc_sel_t;

  function automatic wdc_sel_t wdc_decode(input logic [ADDR_W-1:0] a);
    wdc_sel_t s;
    s = SEL_NONE;
    if (a[1:0] == 2'h0 && a[ADDR_W-1:18] == '0) begin
      case (a[17:2])
        IDX_COUNTER: s = SEL_CNT;
        IDX_KEY:     s = SEL_KEY;
        IDX_CONTROL: s = SEL_CR;
        IDX_SYSCTL:  s = SEL_SYS;
        IDX_IRQ_STS: s = SEL_STS;
        IDX_IRQ_MSK: s = SEL_MSK;
        default:     s = SEL_NONE;
      endcase
    end
    return s;
  endfunction : wdc_decode

  function automatic logic [PRE_W-1:0] wdc_tap_mask(input logic [2:0] sel);
    logic [PRE_W-1:0] m;
    case (sel)
      3'h0, 3'h1: m = 6'h00;
      3'h2:       m = 6'h01;
      3'h3:       m = 6'h03;
      3'h4:       m = 6'h07;
      3'h5:       m = 6'h0F;
      3'h6:       m = 6'h1F;
      default:    m = 6'h3F;
    endcase
    return m;
  endfunction : wdc_tap_mask

endpackage : wdc_pkg

// ===== hw/wdc_prescaler.sv
`timescale 1ns/1ps
`default_nettype none

module wdc_prescaler (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ce,
  input  wire logic dog_clock,
  wdc_if.pre        link
);
  import wdc_pkg::*;

  typedef struct packed {
    logic             s1;
    logic             s2;
    logic             s3;
    logic [PRE_W-1:0] pre;
  } wdc_pre_state_t;

  localparam wdc_pre_state_t PRE_RST = '0;

  wdc_pre_state_t   r;
  wdc_pre_state_t   n;
  logic             dog_tick;
  logic [PRE_W-1:0] mask;

  // ---------------------------------------------------------------
  // pin sync, free-running divider, tap select
  // ---------------------------------------------------------------
  always_comb begin
    n        = r;
    n.s1     = dog_clock;
    n.s2     = r.s1;
    n.s3     = r.s2;
    dog_tick = r.s2 & ~r.s3;
    mask     = wdc_tap_mask(link.prescale_sel);
    if (dog_tick) begin
      n.pre = r.pre + 6'h01;
    end
    link.tap_tick = dog_tick && ((r.pre & mask) == mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= PRE_RST;
    end else if (ce) begin
      r <= n;
    end
  end

endmodule : wdc_prescaler

`default_nettype wire

// ===== hw/wdc_top.sv
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module wdc_top (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       ce,
  input  wire logic                       hsel,
  input  wire logic [wdc_pkg::ADDR_W-1:0] haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [wdc_pkg::DATA_W-1:0] hwdata,
  input  wire logic                       hready,
  output logic                            hreadyout,
  output logic                            hresp,
  output logic      [wdc_pkg::DATA_W-1:0] hrdata,
  input  wire logic                       dog_clock,
  input  wire logic                       hv_strap,
  input  wire logic                       sys_rst_req,
  output logic                            dog_reset,
  output logic                            irq
);
  import wdc_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    wdc_run_t          st;
    logic [CNT_W-1:0]  cnt;
    logic              armed;
    logic              flag;
    logic              dis;
    logic [2:0]        ps;
    logic [IRQ_W-1:0]  sts;
    logic [IRQ_W-1:0]  msk;
    logic              hv_s1;
    logic              hv_s2;
    logic              hv;
    logic [1:0]        strap_cnt;
    logic              dp_act;
    logic              dp_wr;
    wdc_sel_t          dp_sel;
    logic [DATA_W-1:0] rdata;
  } wdc_state_t;

  localparam wdc_state_t TOP_RST = '{
    st:        WDC_RUN,
    cnt:       CNT_RST,
    armed:     1'b0,
    flag:      FLAG_RST,
    dis:       DIS_RST,
    ps:        PS_RST,
    sts:       3'h0,
    msk:       3'h0,
    hv_s1:     1'b0,
    hv_s2:     1'b0,
    hv:        1'b0,
    strap_cnt: 2'h0,
    dp_act:    1'b0,
    dp_wr:     1'b0,
    dp_sel:    SEL_NONE,
    rdata:     32'h0000_0000
  };

  wdc_state_t r;
  wdc_state_t n;
  wdc_if      pre_link ();

  logic       enabled;
  logic       fire;
  logic       kick;
  logic       ovf_ev;
  logic       addr_take;
  wdc_sel_t   addr_sel;
  logic [7:0] wbyte;

  // ---------------------------------------------------------------
  // read view of the control byte
  // ---------------------------------------------------------------
  function automatic logic [7:0] ctrl_byte(input wdc_state_t s);
    logic [7:0] b;
    b           = 8'h00;
    b[FLAG_BIT] = s.flag;
    b[DIS_BIT]  = s.dis;
    b[PS_HI:PS_LO] = s.ps;
    return b;
  endfunction : ctrl_byte

  function automatic logic [DATA_W-1:0] read_word(input wdc_sel_t sel,
                                                  input wdc_state_t s);
    logic [DATA_W-1:0] w;
    w = 32'h0000_0000;
    case (sel)
      SEL_CNT: w[CNT_W-1:0] = s.cnt;
      SEL_KEY: w[7:0]       = ctrl_byte(s);
      SEL_CR:  w[7:0]       = ctrl_byte(s);
      SEL_SYS: w[0]         = s.hv;
      SEL_STS: w[IRQ_W-1:0] = s.sts;
      SEL_MSK: w[IRQ_W-1:0] = s.msk;
      default: w            = 32'h0000_0000;
    endcase
    return w;
  endfunction : read_word

  // ---------------------------------------------------------------
  // prescaler
  // ---------------------------------------------------------------
  assign pre_link.prescale_sel = r.ps;

  wdc_prescaler u_pre (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .ce        (ce),
    .dog_clock (dog_clock),
    .link      (pre_link.pre)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    n         = r;
    fire      = 1'b0;
    kick      = 1'b0;
    ovf_ev    = 1'b0;
    wbyte     = hwdata[7:0];
    addr_take = hsel && hready && (htrans == HTRANS_NONSEQ);
    addr_sel  = wdc_decode(haddr);

    // strap sampled after release, second stage only
    n.hv_s1 = hv_strap;
    n.hv_s2 = r.hv_s1;
    if (r.strap_cnt != STRAP_WAIT) begin
      n.strap_cnt = r.strap_cnt + 2'h1;
      n.hv        = r.hv_s2;
    end
    enabled = !(r.hv && r.dis);

    // bus address phase
    n.dp_act = 1'b0;
    if (addr_take) begin
      n.dp_act = 1'b1;
      n.dp_wr  = hwrite && (hsize == HSIZE_WORD);
      n.dp_sel = addr_sel;
      if (!hwrite) begin
        n.rdata = read_word(addr_sel, r);
      end
    end

    // bus data phase writes
    if (r.dp_act && r.dp_wr) begin
      case (r.dp_sel)
        SEL_KEY: begin
          if (wbyte == KEY_ARM) begin
            n.armed = 1'b1;
          end else if (wbyte == KEY_FIRE) begin
            kick    = r.armed;
            n.armed = 1'b0;
          end else begin
            fire = 1'b1;
          end
        end
        SEL_CR: begin
          if (wbyte[CHK_HI:CHK_LO] != CHK_PATTERN) begin
            fire = 1'b1;
          end else begin
            n.dis = wbyte[DIS_BIT];
            n.ps  = wbyte[PS_HI:PS_LO];
            if (!wbyte[FLAG_BIT]) begin
              n.flag = 1'b0;
            end
          end
        end
        SEL_STS: n.sts = r.sts & ~hwdata[IRQ_W-1:0];
        SEL_MSK: n.msk = hwdata[IRQ_W-1:0];
        default: n.sts = r.sts;
      endcase
    end

    // counter and overflow sequence
    unique case (r.st)
      WDC_RUN: begin
        if (kick) begin
          n.cnt = CNT_RST;
        end else if (enabled && pre_link.tap_tick) begin
          if (r.cnt == CNT_TOP) begin
            n.cnt  = CNT_RST;
            n.st   = WDC_OVF;
            ovf_ev = 1'b1;
          end else begin
            n.cnt = r.cnt + 8'h01;
          end
        end
      end
      WDC_OVF: begin
        if (kick) begin
          n.cnt = CNT_RST;
          n.st  = WDC_RUN;
        end else if (enabled && pre_link.tap_tick) begin
          fire = 1'b1;
        end
      end
      WDC_FIRE: begin
        n.st    = WDC_RUN;
        n.cnt   = CNT_RST;
        n.armed = 1'b0;
        n.dis   = DIS_RST;
        n.ps    = PS_RST;
        n.flag  = 1'b1;
      end
    endcase
    if (fire) begin
      n.st = WDC_FIRE;
    end

    // sticky events, set wins over clear
    if (ovf_ev) begin
      n.sts[IRQ_OVF] = 1'b1;
    end
    if (kick) begin
      n.sts[IRQ_KICK] = 1'b1;
    end
    if (r.st == WDC_FIRE) begin
      n.sts[IRQ_DOGRST] = 1'b1;
    end

    // foreign system reset keeps the flag
    if (sys_rst_req) begin
      n.st     = WDC_RUN;
      n.cnt    = CNT_RST;
      n.armed  = 1'b0;
      n.dis    = DIS_RST;
      n.ps     = PS_RST;
      n.sts    = 3'h0;
      n.msk    = 3'h0;
      n.dp_act = 1'b0;
      n.flag   = r.flag;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= TOP_RST;
    end else if (ce) begin
      r <= n;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign hreadyout = ce;
  assign hresp     = 1'b0;
  assign hrdata    = r.rdata;
  assign dog_reset = (r.st == WDC_FIRE);
  assign irq       = |(r.sts & r.msk);

endmodule : wdc_top

`default_nettype wire

// ===== test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import wdc_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, dog_clock, hv_strap, sys_rst_req;
  logic        hreadyout, hresp, dog_reset, irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, c1;
  logic [2:0]  bad [3];
  int          n_mismatch, n_checks, n_fire, f;

  wdc_top i_dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dog_clock(dog_clock),
    .hv_strap(hv_strap), .sys_rst_req(sys_rst_req), .dog_reset(dog_reset), .irq(irq));

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  always @(negedge hclk) if (dog_reset === 1'b1) n_fire++;

  // ----------
  // tasks
  // ----------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic wait_rdy;
    int i;
    i = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      i++;
      if (i > 20) begin
        n_mismatch++;
        stop_test();
      end
      @(posedge hclk);
    end
  endtask : wait_rdy

  task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize  <= HSIZE_WORD;
    haddr  <= {14'h0, idx, 2'h0};
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    xfer(1'b1, idx, d);
  endtask : wr

  task automatic rdc(input logic [15:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask : rdc

  task automatic kick;
    wr(IDX_KEY, 32'h55);
    wr(IDX_KEY, 32'hAA);
  endtask : kick

  task automatic ticks(input int n);
    repeat (n) begin
      dog_clock <= 1'b1;
      repeat (8) @(posedge hclk);
      dog_clock <= 1'b0;
      repeat (8) @(posedge hclk);
    end
  endtask : ticks

  task automatic do_reset(input logic strap);
    hv_strap <= strap;
    hresetn  <= 1'b0;
    repeat (20) @(posedge hclk);
    hresetn  <= 1'b1;
    repeat (4) @(posedge hclk);
  endtask : do_reset

  initial begin
    #600000;
    n_mismatch++;
    stop_test();
  end

  // ----------
  // main sequence
  // ----------
  initial begin
    {hsel, hwrite, dog_clock, sys_rst_req, htrans, hsize, haddr, hwdata} = '0;
    hresetn = 1'b0;
    hv_strap = 1'b1;
    bad = '{3'h4, 3'h7, 3'h1};
    @(posedge hclk);
    do_reset(1'b1);
    rdc(IDX_CONTROL, 32'h0);
    rdc(IDX_SYSCTL, 32'h1);
    rdc(16'h7024, 32'h0);
    wr(IDX_CONTROL, 32'h6F);
    rdc(IDX_CONTROL, 32'h47);
    rdc(IDX_KEY, 32'h47);
    ticks(64);
    rdc(IDX_COUNTER, 32'h0);
    for (int c = 0; c < 8; c++) begin
      wr(IDX_CONTROL, 32'h28 | c);
      kick();
      ticks(64);
      rdc(IDX_COUNTER, 64 >> (c < 2 ? 0 : c - 1));
    end
    kick();
    ticks(32);
    xfer(1'b0, IDX_COUNTER, 32'h0);
    c1 = rd;
    kick();
    ticks(32);
    rdc(IDX_COUNTER, 32'h1 - c1);
    rdc(IDX_IRQ_STS, 32'h2);
    chk(irq, 1'b0);
    wr(IDX_IRQ_MSK, 32'h7);
    rdc(IDX_IRQ_MSK, 32'h7);
    chk(irq, 1'b1);
    wr(IDX_CONTROL, 32'h28);
    kick();
    wr(IDX_IRQ_STS, 32'h7);
    rdc(IDX_IRQ_STS, 32'h0);
    chk(irq, 1'b0);
    ticks(255);
    rdc(IDX_COUNTER, 32'hFF);
    ticks(1);
    chk(n_fire, 0);
    rdc(IDX_IRQ_STS, 32'h1);
    ticks(1);
    chk(n_fire, 1);
    rdc(IDX_CONTROL, 32'h80);
    rdc(IDX_IRQ_STS, 32'h5);
    chk(irq, 1'b1);
    wr(IDX_CONTROL, 32'hAF);
    rdc(IDX_CONTROL, 32'h87);
    sys_rst_req <= 1'b1;
    @(posedge hclk);
    sys_rst_req <= 1'b0;
    rdc(IDX_CONTROL, 32'h80);
    rdc(IDX_IRQ_MSK, 32'h0);
    wr(IDX_CONTROL, 32'h28);
    rdc(IDX_CONTROL, 32'h0);
    for (int i = 0; i < 3; i++) begin
      f = n_fire;
      wr(IDX_CONTROL, {26'h0, bad[i], 3'h3});
      repeat (3) @(posedge hclk);
      chk(n_fire, f + 1);
      rdc(IDX_CONTROL, 32'h80);
    end
    f = n_fire;
    wr(IDX_KEY, 32'h12);
    repeat (3) @(posedge hclk);
    chk(n_fire, f + 1);
    ticks(2);
    wr(IDX_KEY, 32'hAA);
    rdc(IDX_COUNTER, 32'h2);
    wr(IDX_KEY, 32'h55);
    kick();
    rdc(IDX_COUNTER, 32'h0);
    chk(n_fire, f + 1);
    do_reset(1'b0);
    rdc(IDX_SYSCTL, 32'h0);
    wr(IDX_CONTROL, 32'h6A);
    ticks(4);
    rdc(IDX_COUNTER, 32'h2);
    stop_test();
  end
endmodule : tb_top

`default_nettype wire

// ===== test/wdc_properties.sv
`timescale 1ns/1ps
`default_nettype none

module wdc_properties
  import wdc_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        ce,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        sys_rst_req,
  input wire logic        dog_reset,
  input wire logic        irq
);
  // ----------
  // data phase tracking
  // ----------
  logic       ap;
  logic       wcr_r, wkey_r, wmsk_r, rcr_r, rkey_r;
  logic [2:0] msk_r;

  assign ap = hsel && hready && htrans == HTRANS_NONSEQ && ce;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wcr_r, wkey_r, wmsk_r, rcr_r, rkey_r, msk_r} <= '0;
    end else if (sys_rst_req && ce) begin
      {wcr_r, wkey_r, wmsk_r, rcr_r, rkey_r, msk_r} <= '0;
    end else if (hready && ce) begin
      wcr_r  <= ap && hwrite && hsize == HSIZE_WORD && haddr == {14'h0, IDX_CONTROL, 2'h0};
      wkey_r <= ap && hwrite && hsize == HSIZE_WORD && haddr == {14'h0, IDX_KEY, 2'h0};
      wmsk_r <= ap && hwrite && hsize == HSIZE_WORD && haddr == {14'h0, IDX_IRQ_MSK, 2'h0};
      rcr_r  <= ap && !hwrite && haddr == {14'h0, IDX_CONTROL, 2'h0};
      rkey_r <= ap && !hwrite && haddr == {14'h0, IDX_KEY, 2'h0};
      if (wmsk_r) msk_r <= hwdata[2:0];
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ----------
  // properties
  // ----------
  chk_bad_check_fire: assert property (wcr_r && hwdata[5:3] != CHK_PATTERN |-> ##[1:2] dog_reset)
    else $error("bad check bits gave no reset");
  chk_bad_key_fire: assert property (
    wkey_r && hwdata[7:0] != KEY_ARM && hwdata[7:0] != KEY_FIRE |-> ##[1:2] dog_reset)
    else $error("bad key gave no reset");
  chk_check_reads_zero: assert property (rcr_r |-> hrdata[5:3] == 3'h0 && hrdata[31:8] == '0)
    else $error("control read shows check bits");
  chk_key_reads_ctl: assert property (rkey_r |-> hrdata[5:3] == 3'h0 && hrdata[31:8] == '0)
    else $error("key read is not the control byte");
  chk_fire_one_cycle: assert property (dog_reset |=> !dog_reset)
    else $error("reset pulse longer than one cycle");
  chk_fire_irq: assert property (dog_reset && msk_r[IRQ_DOGRST] |-> ##[1:2] irq)
    else $error("unmasked reset event gave no irq");
  chk_quiet_release: assert property ($rose(hresetn) |-> !dog_reset && !irq)
    else $error("outputs active after reset release");
  chk_okay_resp: assert property (hresp == 1'b0)
    else $error("response not okay");
  chk_ready_ce: assert property (hreadyout == ce)
    else $error("ready does not follow enable");

  cover property (dog_reset);
  cover property (rcr_r);
  cover property (wkey_r && hwdata[7:0] == KEY_FIRE);
endmodule : wdc_properties

bind wdc_top wdc_properties u_chk (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .sys_rst_req(sys_rst_req), .dog_reset(dog_reset), .irq(irq));

`default_nettype wire
